// ---- hw/chgreg_pkg.sv ----
// Purpose: Shared constants for the charger status and configuration registers
// Assumes: Byte-wide register port addressed by 8-bit register index
// Notes: Status codes follow the detail-field encodings of the register map
package chgreg_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_DETAIL_ONE = 8'h14;
  localparam logic [7:0] ADDR_DETAIL_TWO = 8'h15;
  localparam logic [7:0] ADDR_CONTROL_ZERO = 8'h16;
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'h17;
  localparam logic [7:0] ADDR_FAST_CURRENT = 8'h18;
  localparam logic [7:0] ADDR_WATCHDOG_CLEAR = 8'h1B;
  // Reset values
  localparam logic [3:0] RST_MODE = 4'h5;
  localparam logic [7:0] RST_CONTROL_ONE = 8'hD9;
  localparam logic [7:0] RST_FAST_CURRENT = 8'h40;
  localparam logic [1:0] WDT_CLEAR_CODE = 2'h1;
  // Battery detail codes
  localparam logic [2:0] BAT_REMOVED = 3'h0;
  localparam logic [2:0] BAT_BELOW_PRECHG = 3'h1;
  localparam logic [2:0] BAT_TIMER_FAULT = 3'h2;
  localparam logic [2:0] BAT_OKAY = 3'h3;
  localparam logic [2:0] BAT_LOW = 3'h4;
  localparam logic [2:0] BAT_OVERVOLT = 3'h5;
  localparam logic [2:0] BAT_OVERCURR = 3'h6;
  localparam logic [2:0] BAT_UNAVAIL = 3'h7;
  // Charger detail codes
  localparam logic [3:0] CHG_PRECHG = 4'h0;
  localparam logic [3:0] CHG_FAST_CC = 4'h1;
  localparam logic [3:0] CHG_FAST_CV = 4'h2;
  localparam logic [3:0] CHG_TOPOFF = 4'h3;
  localparam logic [3:0] CHG_DONE = 4'h4;
  localparam logic [3:0] CHG_RES_CONFIG = 4'h5;
  localparam logic [3:0] CHG_TIMER_FAULT = 4'h6;
  localparam logic [3:0] CHG_SWITCH_OFF = 4'h7;
  localparam logic [3:0] CHG_OFF = 4'h8;
  localparam logic [3:0] CHG_THERMAL = 4'hA;
  localparam logic [3:0] CHG_WATCHDOG = 4'hB;
  localparam logic [3:0] CHG_ZONE_LIMIT = 4'hC;
  localparam logic [3:0] CHG_THM_REMOVED = 4'hD;
  // Thermistor zones
  localparam logic [2:0] THM_COLD = 3'h0;
  localparam logic [2:0] THM_NORMAL = 3'h2;
  localparam logic [2:0] THM_HOT = 3'h4;
  localparam logic [2:0] THM_REMOVED = 3'h5;
  localparam logic [2:0] THM_DISABLED = 3'h6;
  // Modes
  localparam logic [3:0] MODE_BUCK_ONLY = 4'h4;
  localparam logic [3:0] MODE_REVERSE = 4'hA;
  localparam logic [1:0] RESTART_OFF = 2'h3;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int OVERVOLT_MS = 30;
  localparam int OVERCURR_MS = 3;
  localparam int OVERVOLT_CYCLES = CLK_HZ / 1000 * OVERVOLT_MS;
  localparam int OVERCURR_CYCLES = CLK_HZ / 1000 * OVERCURR_MS;
  localparam int WDT_PERIOD_S = 80;
  localparam longint WDT_CYCLES = longint'(CLK_HZ) * WDT_PERIOD_S;
  // Charger state machine
  typedef enum logic [2:0] {
    CS_IDLE, CS_PRECHG, CS_FAST_CC, CS_FAST_CV, CS_TOPOFF, CS_DONE, CS_FAULT
  } chgreg_state_type;
endpackage : chgreg_pkg

// ---- hw/chgreg_regs.sv ----
// Purpose: Charger status and configuration register bank with its control logic
// Assumes: Host bus already decoded to byte strobes; analog inputs synchronous to clk
// Notes: Status fields are registered every cycle so a read sees one coherent snapshot
// Behaviour
// - Temperature-regulation bit 7 follows junction temperature against regulation threshold.
// - Battery detail priority: overcurrent, missing, overvoltage, timer fault, below prequal.
// - Battery-only mode reports code 7, or code 6 on overcurrent; only overcurrent monitored.
// - Overvoltage code 5 after 30ms above threshold, only with valid input.
// - Overcurrent code 6 when 3ms overcurrent seen since last detail read.
// - Battery detail codes 0 to 4: removed, precharge, timer, okay, low.
// - Charger detail codes 0 to 4: precharge, CC, CV, top-off, done.
// - Charger detail fault codes 5 to D; 9, E, F reserved.
// - Thermistor detail zones coded 0 to 6, 7 reserved.
// - Switching frequency reported in bits 2:1 of detail two.
// - Cell count reported in bit 0 of detail two.
// - Programming-source bit is set-only; writing zero is ignored.
// - Setting programming source clears resistor-config suspension and restarts charging.
// - With programming source clear, limits come from resistor straps.
// - Battery-switch disable forces switch off; readback ORs pin state.
// - Standby bit forces converter off; otherwise power path controls it.
// - Watchdog enabled needs periodic clear write, else charging stops, code B.
// - Mode field selects off, buck, charge or reverse buck; readback active.
// - Prequal enable bit 7; prequal timer bit 6 gates prequal timer fault.
// - Restart threshold field 5:4; code 3 disables restart.
// - Fast-charge timer: 0 disabled, 1-6 three to eight hours, 7 ten.
// - Fast-charge current resets to 0x40, 6.25mA steps; readback applied value.
// - Charger-change flag sets when charger okay changes, clears on read.
`timescale 1ns/1ps
`default_nettype none
module chgreg_regs #(
  parameter longint WDT_CYCLES = chgreg_pkg::WDT_CYCLES,
  parameter int OVERVOLT_CYCLES = chgreg_pkg::OVERVOLT_CYCLES,
  parameter int OVERCURR_CYCLES = chgreg_pkg::OVERCURR_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Analog comparator and strap inputs
  input wire logic inputValid,
  input wire logic batteryOnly,
  input wire logic junctionOverReg,
  input wire logic thermalShutdown,
  input wire logic battSysOvercurrent,
  input wire logic battOvervoltage,
  input wire logic battMissing,
  input wire logic battBelowPrechg,
  input wire logic battBelowSysmin,
  input wire logic battAtRegulation,
  input wire logic chargeBelowTopoff,
  input wire logic battBelowRestart,
  input wire logic fastTimerExpired,
  input wire logic prequalTimerExpired,
  input wire logic resistorConfigBad,
  input wire logic [2:0] thermistorZone,
  input wire logic [1:0] switchFreqStrap,
  input wire logic cellCountStrap,
  input wire logic batterySwitchDisablePin,
  input wire logic [7:0] strapChargeCurrent,
  // Outputs to power stage
  output logic chargeEnable,
  output logic converterEnable,
  output logic reverseBuckEnable,
  output logic batterySwitchOff,
  output logic inputStandby,
  output logic [7:0] appliedChargeCurrent,
  output logic chargerChangeFlag
);
  logic hostProgramSelect;
  logic batterySwitchDisable;
  logic inputStandbyEnable;
  logic watchdogEnable;
  logic [3:0] mode;
  logic [7:0] controlOne;
  logic [7:0] fastChargeCurrent;
  logic tempRegulationFlag;
  logic [2:0] batteryDetail;
  logic [3:0] chargerDetail;
  logic [2:0] thermistorDetail;
  logic [1:0] switchFreqDetail;
  logic cellCountDetail;
  logic chargerOkay;
  logic resSuspended;
  logic watchdogExpired;
  logic [39:0] wdtCount;
  logic [31:0] ovCount;
  logic [31:0] ocCount;
  logic ovFlag;
  logic ocLatched;
  logic [2:0] next_batteryDetail;
  logic [3:0] next_chargerDetail;
  logic next_chargerOkay;
  chgreg_pkg::chgreg_state_type state;

  function automatic logic isWrite(input logic [7:0] a, input logic [7:0] target,
                                   input logic we);
    isWrite = we && (a == target);
  endfunction : isWrite

  wire logic readDetailOne = regRead && (regAddr == chgreg_pkg::ADDR_DETAIL_ONE);
  wire logic chargeMode = mode[3:2] == 2'h1 && mode[1:0] != 2'h0;
  wire logic [1:0] restartThreshold = controlOne[5:4];
  wire logic prequalEnable = controlOne[7];
  wire logic prequalTimerEnable = controlOne[6];
  wire logic [2:0] fastChargeTimer = controlOne[2:0];

  // Control register zero
  always_ff @(posedge clk) begin
    if (srst) begin
      hostProgramSelect <= 1'b0;
      batterySwitchDisable <= 1'b0;
      inputStandbyEnable <= 1'b0;
      watchdogEnable <= 1'b0;
      mode <= chgreg_pkg::RST_MODE;
    end else if (isWrite(regAddr, chgreg_pkg::ADDR_CONTROL_ZERO, regWrite)) begin
      if (regWdata[7]) begin
        hostProgramSelect <= 1'b1;
      end
      batterySwitchDisable <= regWdata[6];
      inputStandbyEnable <= regWdata[5];
      watchdogEnable <= regWdata[4];
      // Reserved codes are not accepted so readback stays an active setting
      if (!(regWdata[3:0] inside {4'h8, 4'h9, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF})) begin
        mode <= regWdata[3:0];
      end
    end
  end

  // Control register one and charge current
  always_ff @(posedge clk) begin
    if (srst) begin
      controlOne <= chgreg_pkg::RST_CONTROL_ONE;
      fastChargeCurrent <= chgreg_pkg::RST_FAST_CURRENT;
    end else begin
      if (isWrite(regAddr, chgreg_pkg::ADDR_CONTROL_ONE, regWrite)) begin
        controlOne <= regWdata;
      end
      if (isWrite(regAddr, chgreg_pkg::ADDR_FAST_CURRENT, regWrite)) begin
        fastChargeCurrent <= regWdata;
      end
    end
  end

  // Resistor-configuration suspension, released by selecting host programming
  always_ff @(posedge clk) begin
    if (srst) begin
      resSuspended <= 1'b0;
    end else if (isWrite(regAddr, chgreg_pkg::ADDR_CONTROL_ZERO, regWrite) && regWdata[7]) begin
      resSuspended <= 1'b0;
    end else if (!hostProgramSelect && resistorConfigBad) begin
      resSuspended <= 1'b1;
    end
  end

  // Watchdog: period restarts on a clear write while enabled
  always_ff @(posedge clk) begin
    if (srst || !watchdogEnable) begin
      wdtCount <= '0;
      watchdogExpired <= 1'b0;
    end else if (isWrite(regAddr, chgreg_pkg::ADDR_WATCHDOG_CLEAR, regWrite)
                 && regWdata[1:0] == chgreg_pkg::WDT_CLEAR_CODE) begin
      wdtCount <= '0;
      watchdogExpired <= 1'b0;
    end else if (wdtCount >= 40'(WDT_CYCLES - 1)) begin
      watchdogExpired <= 1'b1;
    end else begin
      wdtCount <= wdtCount + 40'h1;
    end
  end

  // Overvoltage debounce needs a valid input the whole time
  always_ff @(posedge clk) begin
    if (srst || !battOvervoltage || !inputValid || batteryOnly) begin
      ovCount <= '0;
      ovFlag <= 1'b0;
    end else if (ovCount >= 32'(OVERVOLT_CYCLES - 1)) begin
      ovFlag <= 1'b1;
    end else begin
      ovCount <= ovCount + 32'h1;
    end
  end

  // Overcurrent is latched until the detail register is read; a new event wins
  always_ff @(posedge clk) begin
    if (srst) begin
      ocCount <= '0;
      ocLatched <= 1'b0;
    end else begin
      if (!battSysOvercurrent) begin
        ocCount <= '0;
      end else if (ocCount < 32'(OVERCURR_CYCLES)) begin
        ocCount <= ocCount + 32'h1;
      end
      if (battSysOvercurrent && ocCount >= 32'(OVERCURR_CYCLES - 1)) begin
        ocLatched <= 1'b1;
      end else if (readDetailOne) begin
        ocLatched <= 1'b0;
      end
    end
  end

  // Charger state machine
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= chgreg_pkg::CS_IDLE;
    end else if (!chargeEnable) begin
      state <= chgreg_pkg::CS_IDLE;
    end else begin
      unique case (state)
        chgreg_pkg::CS_IDLE: begin
          state <= (prequalEnable && battBelowSysmin) ? chgreg_pkg::CS_PRECHG
                                                      : chgreg_pkg::CS_FAST_CC;
        end
        chgreg_pkg::CS_PRECHG: begin
          if (prequalTimerEnable && prequalTimerExpired) begin
            state <= chgreg_pkg::CS_FAULT;
          end else if (!battBelowSysmin) begin
            state <= chgreg_pkg::CS_FAST_CC;
          end
        end
        chgreg_pkg::CS_FAST_CC: begin
          if (fastChargeTimer != 3'h0 && fastTimerExpired) begin
            state <= chgreg_pkg::CS_FAULT;
          end else if (battAtRegulation) begin
            state <= chgreg_pkg::CS_FAST_CV;
          end
        end
        chgreg_pkg::CS_FAST_CV: begin
          if (fastChargeTimer != 3'h0 && fastTimerExpired) begin
            state <= chgreg_pkg::CS_FAULT;
          end else if (chargeBelowTopoff) begin
            state <= chgreg_pkg::CS_TOPOFF;
          end
        end
        chgreg_pkg::CS_TOPOFF: begin
          if (fastTimerExpired) begin
            state <= chgreg_pkg::CS_DONE;
          end
        end
        chgreg_pkg::CS_DONE: begin
          if (restartThreshold != chgreg_pkg::RESTART_OFF && battBelowRestart) begin
            state <= chgreg_pkg::CS_FAST_CC;
          end
        end
        chgreg_pkg::CS_FAULT: begin
          state <= chgreg_pkg::CS_FAULT;
        end
      endcase
    end
  end

  // Battery detail with fault priority
  always_comb begin
    if (batteryOnly) begin
      next_batteryDetail = ocLatched ? chgreg_pkg::BAT_OVERCURR : chgreg_pkg::BAT_UNAVAIL;
    end else if (ocLatched) begin
      next_batteryDetail = chgreg_pkg::BAT_OVERCURR;
    end else if (battMissing || thermistorZone == chgreg_pkg::THM_REMOVED) begin
      next_batteryDetail = chgreg_pkg::BAT_REMOVED;
    end else if (ovFlag) begin
      next_batteryDetail = chgreg_pkg::BAT_OVERVOLT;
    end else if (state == chgreg_pkg::CS_FAULT) begin
      next_batteryDetail = chgreg_pkg::BAT_TIMER_FAULT;
    end else if (battBelowPrechg) begin
      next_batteryDetail = chgreg_pkg::BAT_BELOW_PRECHG;
    end else if (battBelowSysmin) begin
      next_batteryDetail = chgreg_pkg::BAT_LOW;
    end else begin
      next_batteryDetail = chgreg_pkg::BAT_OKAY;
    end
  end

  // Charger detail, most severe cause first
  always_comb begin
    next_chargerOkay = 1'b0;
    if (thermalShutdown) begin
      next_chargerDetail = chgreg_pkg::CHG_THERMAL;
    end else if (resSuspended) begin
      next_chargerDetail = chgreg_pkg::CHG_RES_CONFIG;
    end else if (watchdogExpired) begin
      next_chargerDetail = chgreg_pkg::CHG_WATCHDOG;
    end else if (!inputValid || !chargeMode || inputStandbyEnable) begin
      next_chargerDetail = chgreg_pkg::CHG_OFF;
      next_chargerOkay = 1'b1;
    end else if (batterySwitchDisable || batterySwitchDisablePin) begin
      next_chargerDetail = chgreg_pkg::CHG_SWITCH_OFF;
    end else if (thermistorZone == chgreg_pkg::THM_REMOVED) begin
      next_chargerDetail = chgreg_pkg::CHG_THM_REMOVED;
    end else if (state == chgreg_pkg::CS_FAULT) begin
      next_chargerDetail = chgreg_pkg::CHG_TIMER_FAULT;
    end else if (thermistorZone != chgreg_pkg::THM_NORMAL
                 && thermistorZone != chgreg_pkg::THM_DISABLED) begin
      next_chargerDetail = chgreg_pkg::CHG_ZONE_LIMIT;
    end else begin
      next_chargerOkay = !junctionOverReg && state != chgreg_pkg::CS_DONE;
      unique case (state)
        chgreg_pkg::CS_FAST_CC: next_chargerDetail = chgreg_pkg::CHG_FAST_CC;
        chgreg_pkg::CS_FAST_CV: next_chargerDetail = chgreg_pkg::CHG_FAST_CV;
        chgreg_pkg::CS_TOPOFF: next_chargerDetail = chgreg_pkg::CHG_TOPOFF;
        chgreg_pkg::CS_DONE: next_chargerDetail = chgreg_pkg::CHG_DONE;
        default: next_chargerDetail = chgreg_pkg::CHG_PRECHG;
      endcase
    end
  end

  // Status snapshot
  always_ff @(posedge clk) begin
    if (srst) begin
      tempRegulationFlag <= 1'b0;
      batteryDetail <= chgreg_pkg::BAT_UNAVAIL;
      chargerDetail <= chgreg_pkg::CHG_OFF;
      chargerOkay <= 1'b1;
      thermistorDetail <= chgreg_pkg::THM_NORMAL;
      switchFreqDetail <= 2'h0;
      cellCountDetail <= 1'b0;
    end else begin
      tempRegulationFlag <= junctionOverReg;
      batteryDetail <= next_batteryDetail;
      chargerDetail <= next_chargerDetail;
      chargerOkay <= next_chargerOkay;
      thermistorDetail <= (thermistorZone == 3'h7) ? chgreg_pkg::THM_DISABLED
                                                   : thermistorZone;
      switchFreqDetail <= (switchFreqStrap == 2'h3) ? 2'h0 : switchFreqStrap;
      cellCountDetail <= cellCountStrap;
    end
  end

  // Change flag: a change in the same cycle as the read keeps the flag set
  always_ff @(posedge clk) begin
    if (srst) begin
      chargerChangeFlag <= 1'b0;
    end else if (next_chargerOkay != chargerOkay) begin
      chargerChangeFlag <= 1'b1;
    end else if (regRead && regAddr == chgreg_pkg::ADDR_WATCHDOG_CLEAR - 8'h1) begin
      chargerChangeFlag <= 1'b0;
    end
  end

  // Power-stage controls
  always_ff @(posedge clk) begin
    if (srst) begin
      chargeEnable <= 1'b0;
      converterEnable <= 1'b0;
      reverseBuckEnable <= 1'b0;
      batterySwitchOff <= 1'b0;
      inputStandby <= 1'b0;
      appliedChargeCurrent <= chgreg_pkg::RST_FAST_CURRENT;
    end else begin
      chargeEnable <= chargeMode && inputValid && !inputStandbyEnable && !resSuspended
                      && !watchdogExpired && !thermalShutdown;
      converterEnable <= !inputStandbyEnable
                         && (mode == chgreg_pkg::MODE_BUCK_ONLY || chargeMode);
      reverseBuckEnable <= mode == chgreg_pkg::MODE_REVERSE;
      batterySwitchOff <= batterySwitchDisable || batterySwitchDisablePin;
      inputStandby <= inputStandbyEnable;
      appliedChargeCurrent <= hostProgramSelect ? fastChargeCurrent
                                                : strapChargeCurrent;
    end
  end

  // Read data
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        chgreg_pkg::ADDR_DETAIL_ONE:
          regRdata <= {tempRegulationFlag, batteryDetail, chargerDetail};
        chgreg_pkg::ADDR_DETAIL_TWO:
          regRdata <= {1'b0, thermistorDetail, 1'b0, switchFreqDetail, cellCountDetail};
        chgreg_pkg::ADDR_CONTROL_ZERO:
          regRdata <= {hostProgramSelect, batterySwitchDisable || batterySwitchDisablePin,
                       inputStandbyEnable, watchdogEnable, mode};
        chgreg_pkg::ADDR_CONTROL_ONE: regRdata <= controlOne;
        chgreg_pkg::ADDR_FAST_CURRENT: regRdata <= appliedChargeCurrent;
        default: regRdata <= 8'h00;
      endcase
    end
  end
endmodule : chgreg_regs
`default_nettype wire

// ---- tb/chgreg_regs_chk.sv ----
// Purpose: Port-level checks on the charger register bank
// Assumes: One clock, synchronous active-high reset
// Notes: Count parameters come from the bound instance
`timescale 1ns/1ps
`default_nettype none
module chgreg_regs_chk #(
  parameter longint WDT_CYCLES = 50,
  parameter int OVERVOLT_CYCLES = 20,
  parameter int OVERCURR_CYCLES = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  // Status inputs
  input wire logic inputValid,
  input wire logic batteryOnly,
  input wire logic junctionOverReg,
  input wire logic battOvervoltage,
  input wire logic cellCountStrap,
  input wire logic batterySwitchDisablePin,
  // Power stage
  input wire logic chargeEnable,
  input wire logic converterEnable,
  input wire logic reverseBuckEnable,
  input wire logic batterySwitchOff,
  input wire logic inputStandby,
  input wire logic [7:0] appliedChargeCurrent,
  input wire logic chargerChangeFlag
);
  int unsigned ovCount;
  // Saturates so a long overvoltage run cannot wrap back below the bound
  always_ff @(posedge clk) begin
    if (srst || !(inputValid && battOvervoltage && !batteryOnly)) begin
      ovCount <= 0;
    end else if (ovCount < OVERVOLT_CYCLES) begin
      ovCount <= ovCount + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  reset_values_a: assert property ($fell(srst) |-> appliedChargeCurrent == 8'h40
    && regRdata == 8'h00 && !chargerChangeFlag) else $error("reset values wrong");
  temp_flag_read_a: assert property (regRead && regAddr == 8'h14 && junctionOverReg
    && $past(junctionOverReg) && !$past(srst) |=> regRdata[7]) else $error("temp flag not set");
  cell_count_a: assert property (regRead && regAddr == 8'h15 && $stable(cellCountStrap)
    && !$past(srst) |=> regRdata[0] == $past(cellCountStrap)) else $error("cell count");
  overvolt_gate_a: assert property (regRead && regAddr == 8'h14 && ovCount < 10
    && $past(ovCount) < 10 |=> regRdata[6:4] != 3'h5) else $error("early overvoltage");
  standby_a: assert property (regWrite && regAddr == 8'h16 && regWdata[5]
    |-> ##[1:2] inputStandby && !converterEnable) else $error("standby ignored");
  switch_pin_a: assert property (batterySwitchDisablePin
    |-> ##[1:2] batterySwitchOff) else $error("switch pin ignored");
  reverse_mode_a: assert property (regWrite && regAddr == 8'h16 && !regWdata[5]
    && regWdata[3:0] == 4'hA |-> ##[1:2] reverseBuckEnable && !chargeEnable)
    else $error("reverse mode");
  mode_off_a: assert property (regWrite && regAddr == 8'h16 && regWdata[3:2] == 2'h0
    |-> ##[1:2] !(chargeEnable || converterEnable || reverseBuckEnable)) else $error("mode off");
  rdata_hold_a: assert property (!regRead |=> $stable(regRdata)) else $error("rdata moved");
endmodule : chgreg_regs_chk
bind chgreg_regs chgreg_regs_chk #(.WDT_CYCLES(WDT_CYCLES), .OVERVOLT_CYCLES(OVERVOLT_CYCLES),
  .OVERCURR_CYCLES(OVERCURR_CYCLES)) chk (.*);
`default_nettype wire

// ---- tb/chgreg_host.sv ----
// Purpose: Host side of the register port
// Assumes: One-cycle strobes taken at the rising edge
// Notes: Idle lines show the inverse of the last value so stale data never matches
`timescale 1ns/1ps
`default_nettype none
module chgreg_host (
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  initial begin
    regAddr = 8'hFF;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 8'hFF;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1 d = regRdata;
  endtask : rd
  task automatic kick();
    wr(chgreg_pkg::ADDR_WATCHDOG_CLEAR, {6'h00, chgreg_pkg::WDT_CLEAR_CODE});
  endtask : kick
endmodule : chgreg_host
`default_nettype wire

// ---- tb/chgreg_regs_tb.sv ----
// Purpose: Self-checking bench for the charger register bank
// Assumes: Small count parameters 50/20/10
// Notes: Inputs change by non-blocking assignment, results read through the register port and the power-stage outputs
`timescale 1ns/1ps
`default_nettype none
module chgreg_regs_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] regAddr, regWdata, regRdata, appliedChargeCurrent, d;
  logic regWrite, regRead, chargeEnable, converterEnable, reverseBuckEnable;
  logic batterySwitchOff, inputStandby, chargerChangeFlag;
  logic inputValid = 1'b1, batteryOnly = 1'b0, junctionOverReg = 1'b0, thermalShutdown = 1'b0;
  logic battSysOvercurrent = 1'b0, battOvervoltage = 1'b0, battMissing = 1'b0;
  logic battBelowPrechg = 1'b0, battBelowSysmin = 1'b0, battAtRegulation = 1'b0;
  logic chargeBelowTopoff = 1'b0, battBelowRestart = 1'b0, fastTimerExpired = 1'b0;
  logic prequalTimerExpired = 1'b0, resistorConfigBad = 1'b0, cellCountStrap = 1'b0;
  logic batterySwitchDisablePin = 1'b0;
  logic [2:0] thermistorZone = 3'h2;
  logic [1:0] switchFreqStrap = 2'h0;
  logic [7:0] strapChargeCurrent = 8'h33;
  logic [3:0] mode;
  int miscompares = 0, checks = 0, cycles = 0;
  always #12.5 clk = ~clk;
  chgreg_regs #(.WDT_CYCLES(50), .OVERVOLT_CYCLES(20), .OVERCURR_CYCLES(10)) uut (.*);
  chgreg_host host (.clk, .regAddr, .regWrite, .regRead, .regWdata, .regRdata);
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rx(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    host.rd(a, v);
    chk($sformatf("register %h", a), v & m, e);
  endtask : rx
  task automatic close_out();
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rx(8'h16, 8'hFF, 8'h05);
    rx(8'h17, 8'hFF, chgreg_pkg::RST_CONTROL_ONE);
    rx(8'h18, 8'hFF, strapChargeCurrent);
    host.wr(8'h18, 8'h20);
    host.wr(8'h16, 8'h05);
    rx(8'h16, 8'h80, 8'h00);
    repeat (3) @(posedge clk);
    chk("applied", appliedChargeCurrent, strapChargeCurrent);
    host.wr(8'h16, 8'h85);
    host.wr(8'h16, 8'h05);
    rx(8'h16, 8'hFF, 8'h85);
    repeat (3) @(posedge clk);
    chk("applied", appliedChargeCurrent, 8'h20);
    rx(8'h18, 8'hFF, 8'h20);
    // Reserved codes must leave the previous mode in force
    mode = 4'h5;
    for (int m = 0; m < 16; m++) begin
      host.wr(8'h16, {4'h8, m[3:0]});
      if (m < 8 || m == 10) begin
        mode = m[3:0];
      end
      repeat (3) @(posedge clk);
      chk("enables", {5'h00, chargeEnable, converterEnable, reverseBuckEnable}, {5'h00,
        mode inside {[5:7]}, mode inside {[4:7]}, mode == 4'hA});
      rx(8'h16, 8'h0F, {4'h0, mode});
    end
    host.wr(8'h16, 8'hA5);
    repeat (3) @(posedge clk);
    chk("standby", {6'h00, inputStandby, converterEnable}, 8'h02);
    host.wr(8'h16, 8'h85);
    batterySwitchDisablePin <= 1'b1;
    repeat (3) @(posedge clk);
    chk("switchOff", {7'h00, batterySwitchOff}, 8'h01);
    rx(8'h16, 8'h40, 8'h40);
    rx(8'h14, 8'h0F, 8'h07);
    batterySwitchDisablePin <= 1'b0;
    host.wr(8'h16, 8'h95);
    repeat (2) begin
      repeat (30) @(posedge clk);
      host.kick();
    end
    chk("charging", {7'h00, chargeEnable}, 8'h01);
    repeat (70) @(posedge clk);
    rx(8'h14, 8'h0F, 8'h0B);
    chk("charging", {7'h00, chargeEnable}, 8'h00);
    // Second reset starts the charger afresh from a low battery
    srst <= 1'b1;
    battBelowSysmin <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    host.wr(8'h16, 8'h85);
    repeat (4) @(posedge clk);
    rx(8'h14, 8'h7F, 8'h40);
    battBelowSysmin <= 1'b0;
    repeat (4) @(posedge clk);
    rx(8'h14, 8'h7F, 8'h31);
    battAtRegulation <= 1'b1;
    repeat (4) @(posedge clk);
    rx(8'h14, 8'h7F, 8'h32);
    chargeBelowTopoff <= 1'b1;
    repeat (4) @(posedge clk);
    rx(8'h14, 8'h7F, 8'h33);
    host.rd(8'h1A, d);
    thermalShutdown <= 1'b1;
    repeat (4) @(posedge clk);
    chk("changeFlag", {7'h00, chargerChangeFlag}, 8'h01);
    rx(8'h14, 8'h0F, 8'h0A);
    host.rd(8'h1A, d);
    chk("changeFlag", {7'h00, chargerChangeFlag}, 8'h00);
    thermalShutdown <= 1'b0;
    inputValid <= 1'b0;
    battAtRegulation <= 1'b0;
    chargeBelowTopoff <= 1'b0;
    repeat (4) @(posedge clk);
    rx(8'h14, 8'h0F, 8'h08);
    inputValid <= 1'b1;
    thermistorZone <= 3'h4;
    repeat (4) @(posedge clk);
    rx(8'h14, 8'h0F, 8'h0C);
    thermistorZone <= 3'h5;
    repeat (4) @(posedge clk);
    rx(8'h14, 8'h0F, 8'h0D);
    thermistorZone <= 3'h2;
    fastTimerExpired <= 1'b1;
    repeat (4) @(posedge clk);
    rx(8'h14, 8'h7F, 8'h26);
    battMissing <= 1'b1;
    battOvervoltage <= 1'b1;
    repeat (25) @(posedge clk);
    rx(8'h14, 8'h70, 8'h00);
    battMissing <= 1'b0;
    repeat (4) @(posedge clk);
    rx(8'h14, 8'h70, 8'h50);
    battSysOvercurrent <= 1'b1;
    repeat (12) @(posedge clk);
    battSysOvercurrent <= 1'b0;
    repeat (4) @(posedge clk);
    rx(8'h14, 8'h70, 8'h60);
    rx(8'h14, 8'h70, 8'h50);
    battOvervoltage <= 1'b0;
    fastTimerExpired <= 1'b0;
    battBelowPrechg <= 1'b1;
    inputValid <= 1'b0;
    repeat (4) @(posedge clk);
    rx(8'h14, 8'h70, 8'h10);
    batteryOnly <= 1'b1;
    repeat (4) @(posedge clk);
    rx(8'h14, 8'h70, 8'h70);
    batteryOnly <= 1'b0;
    battBelowPrechg <= 1'b0;
    inputValid <= 1'b0;
    battOvervoltage <= 1'b1;
    repeat (25) @(posedge clk);
    rx(8'h14, 8'h70, 8'h30);
    battOvervoltage <= 1'b0;
    inputValid <= 1'b1;
    junctionOverReg <= 1'b1;
    repeat (4) @(posedge clk);
    rx(8'h14, 8'h80, 8'h80);
    junctionOverReg <= 1'b0;
    repeat (4) @(posedge clk);
    rx(8'h14, 8'h80, 8'h00);
    for (int i = 0; i < 7; i++) begin
      thermistorZone <= i[2:0];
      switchFreqStrap <= 2'(i % 3);
      cellCountStrap <= i[0];
      repeat (3) @(posedge clk);
      rx(8'h15, 8'hFF, {1'b0, i[2:0], 1'b0, 2'(i % 3), i[0]});
    end
    host.wr(8'h17, 8'h3F);
    rx(8'h17, 8'hFF, 8'h3F);
    host.wr(8'h17, 8'hC8);
    rx(8'h17, 8'hFF, 8'hC8);
    close_out();
  end
endmodule : chgreg_regs_tb
`default_nettype wire
